// ==== sdram_bank_map.svh ====
// constants for the inter-bank command tracker
`ifndef SDRAM_BANK_MAP_SVH
`define SDRAM_BANK_MAP_SVH
// -----------------------------------------------------------------
// clock and timing, times in ns
// -----------------------------------------------------------------
`define CLK_PERIOD_NS             8
`define PRECHARGE_PERIOD_NS       18
`define ROW_TO_COLUMN_DELAY_NS    18
`define WRITE_RECOVERY_TIME_NS    12
`define SELF_REFRESH_EXIT_TIME_NS 70
// least times round up to whole cycles
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRECHARGE_PERIOD_CYC       `CEIL_CYC(`PRECHARGE_PERIOD_NS)
`define ROW_TO_COLUMN_DELAY_CYC    `CEIL_CYC(`ROW_TO_COLUMN_DELAY_NS)
`define WRITE_RECOVERY_TIME_CYC    `CEIL_CYC(`WRITE_RECOVERY_TIME_NS)
`define SELF_REFRESH_EXIT_TIME_CYC `CEIL_CYC(`SELF_REFRESH_EXIT_TIME_NS)
// -----------------------------------------------------------------
// organisation defaults
// -----------------------------------------------------------------
`define CAS_LATENCY_DEF  3
`define BURST_LENGTH_DEF 4
`define NUM_BANKS_DEF    4
`define BANK_BITS        2
`define TIMER_BITS       4
// -----------------------------------------------------------------
// strobe codes {ras, cas, we} with chip select low
// -----------------------------------------------------------------
`define STROBE_MODE_LOAD  3'h0
`define STROBE_REFRESH    3'h1
`define STROBE_PRECHARGE  3'h2
`define STROBE_ACTIVE     3'h3
`define STROBE_WRITE      3'h4
`define STROBE_READ       3'h5
`define STROBE_BURST_STOP 3'h6
`define STROBE_NOP        3'h7
`endif

// ==== sdram_bank_pkg.sv ====
// types shared by the inter-bank command tracker
`include "sdram_bank_map.svh"
package sdram_bank_pkg;
  typedef logic [`BANK_BITS-1:0]  bank_t;
  typedef logic [`TIMER_BITS-1:0] timer_t;
  typedef enum logic [3:0] {
    BANK_IDLE        = 4'h0,
    BANK_ACTIVATING  = 4'h1,
    BANK_ACTIVE      = 4'h2,
    BANK_READ        = 4'h3,
    BANK_WRITE       = 4'h4,
    BANK_READ_AP     = 4'h5,
    BANK_WRITE_AP    = 4'h6,
    BANK_RECOVERING  = 4'h7,
    BANK_PRECHARGING = 4'h8
  } bank_state_e;
  typedef enum logic [3:0] {
    CMD_INHIBIT    = 4'h0,
    CMD_NOP        = 4'h1,
    CMD_ACTIVE     = 4'h2,
    CMD_READ       = 4'h3,
    CMD_WRITE      = 4'h4,
    CMD_BURST_STOP = 4'h5,
    CMD_PRECHARGE  = 4'h6,
    CMD_REFRESH    = 4'h7,
    CMD_MODE_LOAD  = 4'h8
  } cmd_e;
  typedef struct packed {cmd_e op; bank_t bank; logic autoPre;} cmd_s;
  typedef struct packed {logic valid; bank_t bank;} beat_s;
endpackage

// ==== sdram_cmd_decode.sv ====
// command decoder: pin levels to a command record
`timescale 1ns/100ps
`default_nettype none
`include "sdram_bank_map.svh"
module sdram_cmd_decode
  import sdram_bank_pkg::*;
(
  input  wire logic  csN,
  input  wire logic  rasN,
  input  wire logic  casN,
  input  wire logic  weN,
  input  wire bank_t bankSel,
  input  wire logic  apBit,
  output var  cmd_s  cmd
);
  wire logic [2:0] strobes;
  wire cmd_e       op;

  assign strobes = {rasN, casN, weN};
  // chip select high is an inhibit, handled as no operation
  assign op = csN                            ? CMD_INHIBIT    : // R21
              (strobes == `STROBE_NOP)        ? CMD_NOP        : // R22
              (strobes == `STROBE_ACTIVE)     ? CMD_ACTIVE     :
              (strobes == `STROBE_READ)       ? CMD_READ       :
              (strobes == `STROBE_WRITE)      ? CMD_WRITE      :
              (strobes == `STROBE_BURST_STOP) ? CMD_BURST_STOP :
              (strobes == `STROBE_PRECHARGE)  ? CMD_PRECHARGE  :
              (strobes == `STROBE_REFRESH)    ? CMD_REFRESH    :
                                                CMD_MODE_LOAD;
  assign cmd = '{op: op, bank: bankSel, autoPre: apBit};
endmodule
`default_nettype wire

// ==== sdram_bank_fsm.sv ====
// state tracker of one bank
`timescale 1ns/100ps
`default_nettype none
`include "sdram_bank_map.svh"
module sdram_bank_fsm
  import sdram_bank_pkg::*;
#(
  parameter int PRE_CYC = `PRECHARGE_PERIOD_CYC,
  parameter int ROW_CYC = `ROW_TO_COLUMN_DELAY_CYC,
  parameter int WR_CYC  = `WRITE_RECOVERY_TIME_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmdAct,
  input  wire logic        cmdRd,
  input  wire logic        cmdWr,
  input  wire logic        cmdPre,
  input  wire logic        autoPre,
  input  wire logic        burstEnd,
  output var  bank_state_e state,
  output var  logic        prechargeStart
);
  localparam timer_t PreLoad = timer_t'(PRE_CYC - 1);
  localparam timer_t RowLoad = timer_t'(ROW_CYC - 1);
  localparam timer_t WrLoad  = timer_t'(WR_CYC - 1);
  bank_state_e state_q, state_d;
  timer_t      timer_q, timer_d;
  logic        preStart_q;

  always_comb begin
    state_d = state_q;
    timer_d = (timer_q != '0) ? timer_q - 1'b1 : timer_q;
    unique case (state_q)
      BANK_IDLE: if (cmdAct) begin
        state_d = BANK_ACTIVATING;
        timer_d = RowLoad;
      end
      BANK_ACTIVATING: if (timer_q == '0) state_d = BANK_ACTIVE; // R04
      BANK_ACTIVE, BANK_READ, BANK_WRITE: begin
        if (cmdRd) state_d = autoPre ? BANK_READ_AP : BANK_READ; // R05 R06
        else if (cmdWr) state_d = autoPre ? BANK_WRITE_AP : BANK_WRITE; // R07
        else if (cmdPre) begin
          state_d = BANK_PRECHARGING;
          timer_d = PreLoad;
        end else if (burstEnd) state_d = BANK_ACTIVE; // R05
      end
      BANK_READ_AP: if (burstEnd) begin
        state_d = BANK_PRECHARGING; // R11
        timer_d = PreLoad;
      end
      BANK_WRITE_AP: if (burstEnd) begin
        state_d = BANK_RECOVERING; // R11
        timer_d = WrLoad;
      end
      BANK_RECOVERING: if (timer_q == '0) begin
        state_d = BANK_PRECHARGING; // R20
        timer_d = PreLoad;
      end
      BANK_PRECHARGING: if (timer_q == '0) state_d = BANK_IDLE; // R03
      default: state_d = BANK_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= BANK_IDLE;
      timer_q    <= '0;
      preStart_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      timer_q    <= timer_d;
      preStart_q <= (state_d == BANK_PRECHARGING) && (state_q != BANK_PRECHARGING);
    end
  end
  assign state          = state_q;
  assign prechargeStart = preStart_q;

  localparam int PreDly = PRE_CYC;
  localparam int RowDly = ROW_CYC;
  localparam int WrDly  = WR_CYC;
  sequence enterRow;  state_q == BANK_IDLE ##1 state_q == BANK_ACTIVATING; endsequence
  sequence enterRec;  state_q != BANK_RECOVERING ##1 state_q == BANK_RECOVERING; endsequence
  preToIdle_a: assert property (@(posedge clk) disable iff (rst) // R03
    preStart_q |-> ##PreDly state_q == BANK_IDLE) else $error("precharge length wrong");
  rowOpen_a: assert property (@(posedge clk) disable iff (rst) // R04
    enterRow |-> ##RowDly state_q == BANK_ACTIVE) else $error("row open delay wrong");
  recoverWait_a: assert property (@(posedge clk) disable iff (rst) // R20
    enterRec |-> ##WrDly (state_q == BANK_PRECHARGING && preStart_q))
    else $error("write recovery length wrong");
endmodule
`default_nettype wire

// ==== sdram_bank_ctrl.sv ====
// inter-bank command acceptance, burst interruption and concurrent auto precharge
//
// Operation
// [R01] commands act only with clock gate high twice and self refresh exit time over
// [R02] a command to bank m is taken only if bank m's state allows it
// [R03] a bank is idle once precharged and the precharge period has passed
// [R04] a bank is row active once the row to column delay has passed
// [R05] plain read or write burst state lasts until the burst ends or is cut
// [R06] read with auto precharge holds until the precharge period ends, then idle
// [R07] write with auto precharge holds until the precharge period ends, then idle
// [R08] refresh, self refresh and mode load only while every bank is idle
// [R09] burst stop acts only on the current burst, whatever the bank field says
// [R10] any state and command pair outside the allowed set is illegal
// [R11] an interrupted auto precharge burst starts its own precharge concurrently
// [R12] a command that does not interrupt leaves the running burst as started
// [R13] read after plain read: old data gives way one CAS latency later
// [R14] write cuts a plain read at registration; mask two clocks before it
// [R15] read cuts a plain write; last write beat is one clock before the read
// [R16] write cuts a plain write at the moment the new write is registered
// [R17] read cutting an auto precharge read starts its precharge at registration
// [R18] write cutting an auto precharge read starts its precharge; mask two clocks
// [R19] read cutting an auto precharge write: precharge after recovery from the read
// [R20] write cutting an auto precharge write: precharge after recovery from the write
// [R21] chip select high is a no operation; running work simply continues
// [R22] commands decode from the four strobes and bank bits at each rising edge
`timescale 1ns/100ps
`default_nettype none
`include "sdram_bank_map.svh"
module sdram_bank_ctrl
  import sdram_bank_pkg::*;
#(
  parameter int NUM_BANKS    = `NUM_BANKS_DEF,
  parameter int CAS_LATENCY  = `CAS_LATENCY_DEF,
  parameter int BURST_LENGTH = `BURST_LENGTH_DEF,
  parameter int PRE_CYC      = `PRECHARGE_PERIOD_CYC,
  parameter int ROW_CYC      = `ROW_TO_COLUMN_DELAY_CYC,
  parameter int WR_CYC       = `WRITE_RECOVERY_TIME_CYC,
  parameter int XSR_CYC      = `SELF_REFRESH_EXIT_TIME_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  cke,
  input  wire logic                  csN,
  input  wire logic                  rasN,
  input  wire logic                  casN,
  input  wire logic                  weN,
  input  wire bank_t                 bankSel,
  input  wire logic                  apBit,
  input  wire logic                  dqm,
  output var  bank_state_e [NUM_BANKS-1:0] bankState,
  output var  logic [NUM_BANKS-1:0]  prechargeStart,
  output var  logic                  readValid,
  output var  bank_t                 readBank,
  output var  logic                  dqDriveEn,
  output var  logic                  writeAccept,
  output var  bank_t                 writeBank,
  output var  logic                  allIdle,
  output var  logic                  selfRefresh,
  output var  logic                  illegalCmd
);
  localparam int CntW = $clog2(BURST_LENGTH + 1);
  localparam int XsrW = $clog2(XSR_CYC + 1);
  localparam logic [CntW-1:0] BlCnt   = CntW'(BURST_LENGTH);
  localparam logic [XsrW-1:0] XsrLoad = XsrW'(XSR_CYC);

  // -----------------------------------------------------------------
  // command decode
  // -----------------------------------------------------------------
  cmd_s dec;
  sdram_cmd_decode u_decode (
    .csN     (csN),
    .rasN    (rasN),
    .casN    (casN),
    .weN     (weN),
    .bankSel (bankSel),
    .apBit   (apBit),
    .cmd     (dec)
  );

  // -----------------------------------------------------------------
  // clock gate and self refresh tracking
  // -----------------------------------------------------------------
  logic            ckePrev_q;
  logic            selfRef_q;
  logic [XsrW-1:0] exitCnt_q;
  wire logic       cmdLive;
  wire logic       enterSref;

  // commands count only with the gate high on this and the last edge
  assign cmdLive = cke & ckePrev_q & ~selfRef_q & (exitCnt_q == '0); // R01

  // -----------------------------------------------------------------
  // per bank state summaries
  // -----------------------------------------------------------------
  wire logic [NUM_BANKS-1:0] stIdle;
  wire logic [NUM_BANKS-1:0] stRow;
  wire logic [NUM_BANKS-1:0] stPreOk;
  wire logic [NUM_BANKS-1:0] stPreAllOk;
  wire logic [NUM_BANKS-1:0] hitBank;
  wire logic [NUM_BANKS-1:0] bankAct;
  wire logic [NUM_BANKS-1:0] bankRd;
  wire logic [NUM_BANKS-1:0] bankWr;
  wire logic [NUM_BANKS-1:0] bankPre;
  wire logic [NUM_BANKS-1:0] burstEnd;
  wire logic                 allIdleNow;

  assign allIdleNow = &stIdle;

  // -----------------------------------------------------------------
  // acceptance of each command against its target bank
  // -----------------------------------------------------------------
  wire bank_state_e tState;
  wire logic        isCmd;
  wire logic        okAct;
  wire logic        okRd;
  wire logic        okWr;
  wire logic        okPre;
  wire logic        okPreAll;
  wire logic        okBst;
  wire logic        okRef;
  wire logic        okLmr;
  wire logic        okAny;

  assign tState   = bankState[dec.bank];
  assign isCmd    = (dec.op != CMD_INHIBIT) && (dec.op != CMD_NOP); // R21
  // the other banks' states never gate a command to bank m
  assign okAct    = cmdLive & (dec.op == CMD_ACTIVE) & (tState == BANK_IDLE); // R02
  assign okRd     = cmdLive & (dec.op == CMD_READ) & stRow[dec.bank]; // R02
  assign okWr     = cmdLive & (dec.op == CMD_WRITE) & stRow[dec.bank]; // R02
  assign okPre    = cmdLive & (dec.op == CMD_PRECHARGE) & ~dec.autoPre & stPreOk[dec.bank];
  assign okPreAll = cmdLive & (dec.op == CMD_PRECHARGE) & dec.autoPre & (&stPreAllOk);
  assign okBst    = cmdLive & (dec.op == CMD_BURST_STOP);
  assign okRef    = cmdLive & (dec.op == CMD_REFRESH) & allIdleNow; // R08
  assign okLmr    = cmdLive & (dec.op == CMD_MODE_LOAD) & allIdleNow; // R08
  assign okAny    = okAct | okRd | okWr | okPre | okPreAll | okBst | okRef | okLmr;
  // refresh with the gate falling enters self refresh
  assign enterSref = ckePrev_q & ~cke & ~selfRef_q & (exitCnt_q == '0) & ~csN
                   & (dec.op == CMD_REFRESH) & allIdleNow; // R08

  // -----------------------------------------------------------------
  // burst engine: one burst runs at a time, over all banks
  // -----------------------------------------------------------------
  logic            burstOn_q;
  logic            burstWrite_q;
  bank_t           burstBank_q;
  logic [CntW-1:0] beatCnt_q;
  wire logic       newBurst;
  wire logic       preHitsBurst;
  wire logic       stopBurst;
  wire logic       contBeat;
  wire logic       readBeat;
  wire beat_s      newBeat;
  wire logic       writeBeat;
  wire bank_t      beatBank;

  assign newBurst     = okRd | okWr;
  assign preHitsBurst = (okPre & (dec.bank == burstBank_q)) | okPreAll;
  // a new burst, a stop or a precharge of its bank cuts the current burst
  assign stopBurst    = burstOn_q & (newBurst | okBst | preHitsBurst | (beatCnt_q == BlCnt)); // R09 R11
  // anything else leaves the burst running as started
  assign contBeat     = burstOn_q & (beatCnt_q != BlCnt) & ~newBurst & ~okBst
                      & ~preHitsBurst; // R12
  assign beatBank     = newBurst ? dec.bank : burstBank_q;
  assign readBeat     = okRd | (contBeat & ~burstWrite_q); // R13
  // the beat taken with a new command belongs to the new bank only
  assign writeBeat    = okWr | (contBeat & burstWrite_q); // R15 R16
  assign newBeat      = '{valid: readBeat, bank: beatBank};

  // -----------------------------------------------------------------
  // banks
  // -----------------------------------------------------------------
  for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
    localparam bank_t Idx = bank_t'(i);
    assign stIdle[i]     = bankState[i] == BANK_IDLE;
    assign stRow[i]      = (bankState[i] == BANK_ACTIVE) || (bankState[i] == BANK_READ)
                        || (bankState[i] == BANK_WRITE);
    assign stPreOk[i]    = stRow[i] || stIdle[i] || (bankState[i] == BANK_PRECHARGING);
    assign stPreAllOk[i] = stPreOk[i] || (bankState[i] == BANK_ACTIVATING);
    assign hitBank[i]    = dec.bank == Idx;
    assign bankAct[i]    = okAct & hitBank[i];
    assign bankRd[i]     = okRd & hitBank[i];
    assign bankWr[i]     = okWr & hitBank[i];
    assign bankPre[i]    = (okPre & hitBank[i]) | okPreAll;
    assign burstEnd[i]   = stopBurst & (burstBank_q == Idx); // R11
    sdram_bank_fsm #(
      .PRE_CYC (PRE_CYC),
      .ROW_CYC (ROW_CYC),
      .WR_CYC  (WR_CYC)
    ) u_fsm (
      .clk            (clk),
      .rst            (rst),
      .cmdAct         (bankAct[i]),
      .cmdRd          (bankRd[i]),
      .cmdWr          (bankWr[i]),
      .cmdPre         (bankPre[i]),
      .autoPre        (dec.autoPre),
      .burstEnd       (burstEnd[i]),
      .state          (bankState[i]),
      .prechargeStart (prechargeStart[i])
    );
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ckePrev_q <= 1'b0;
      selfRef_q <= 1'b0;
      exitCnt_q <= '0;
    end else begin
      ckePrev_q <= cke;
      if (enterSref) selfRef_q <= 1'b1;
      else if (selfRef_q && cke) selfRef_q <= 1'b0;
      // exit time counts from the first edge with the gate back high
      if (selfRef_q && cke) exitCnt_q <= XsrLoad; // R01
      else if (exitCnt_q != '0) exitCnt_q <= exitCnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      burstOn_q    <= 1'b0;
      burstWrite_q <= 1'b0;
      burstBank_q  <= '0;
      beatCnt_q    <= '0;
    end else if (newBurst) begin
      burstOn_q    <= 1'b1;
      burstWrite_q <= okWr;
      burstBank_q  <= dec.bank;
      beatCnt_q    <= CntW'(1);
    end else if (contBeat) begin
      beatCnt_q    <= beatCnt_q + 1'b1;
    end else if (stopBurst) begin
      burstOn_q    <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // read data pipe, one stage per clock of CAS latency
  // -----------------------------------------------------------------
  beat_s [CAS_LATENCY-1:0] pipe_q;
  logic                    dqmLate_q;
  logic                    drive_q;

  always_ff @(posedge clk) begin
    // a registered write takes the bus from reads still in flight
    if (rst || okWr) begin
      pipe_q <= '0; // R14
    end else begin
      pipe_q[0] <= newBeat;
      for (int j = 1; j < CAS_LATENCY; j++) begin
        pipe_q[j] <= pipe_q[j-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dqmLate_q <= 1'b0;
      drive_q   <= 1'b0;
    end else begin
      dqmLate_q <= dqm;
      // mask blanks read output two clocks on
      drive_q   <= pipe_q[CAS_LATENCY-2].valid & ~dqmLate_q & ~okWr; // R14 R18
    end
  end

  // -----------------------------------------------------------------
  // write beats, status flags
  // -----------------------------------------------------------------
  logic  wrAcc_q;
  bank_t wrBank_q;
  logic  allIdle_q;
  logic  illegal_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      wrAcc_q   <= 1'b0;
      wrBank_q  <= '0;
      allIdle_q <= 1'b1;
      illegal_q <= 1'b0;
    end else begin
      wrAcc_q   <= writeBeat & ~dqm; // R15 R16
      wrBank_q  <= beatBank;
      allIdle_q <= allIdleNow;
      // refused pairs do nothing but raise this one-cycle flag
      illegal_q <= cmdLive & isCmd & ~okAny; // R10
    end
  end

  assign readValid   = pipe_q[CAS_LATENCY-1].valid;
  assign readBank    = pipe_q[CAS_LATENCY-1].bank;
  assign dqDriveEn   = drive_q;
  assign writeAccept = wrAcc_q;
  assign writeBank   = wrBank_q;
  assign allIdle     = allIdle_q;
  assign selfRefresh = selfRef_q;
  assign illegalCmd  = illegal_q;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  localparam int CasLat = CAS_LATENCY;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence cutApRead;
    newBurst && burstOn_q && (burstBank_q != dec.bank)
      && (bankState[burstBank_q] == BANK_READ_AP);
  endsequence
  sequence cutApWrite;
    newBurst && burstOn_q && (burstBank_q != dec.bank)
      && (bankState[burstBank_q] == BANK_WRITE_AP);
  endsequence

  apReadCut_a: assert property ( // R17
    cutApRead |=> prechargeStart[$past(burstBank_q)]) else $error("read ap cut no precharge");
  apWriteCut_a: assert property ( // R19
    cutApWrite |=> bankState[$past(burstBank_q)] == BANK_RECOVERING)
    else $error("write ap cut no recovery");
  readLatency_a: assert property ( // R13
    readValid |-> $past(readBeat, CasLat)) else $error("read data at wrong latency");
  writeCut_a: assert property ( // R15
    okRd |=> !writeAccept) else $error("write beat taken with a read");
  dqmBlank_a: assert property ( // R14
    $past(dqm, 2) |-> !dqDriveEn) else $error("masked read still driven");
  gateLive_a: assert property ( // R01
    !cmdLive |-> !(newBurst || okAct || okPre || okPreAll)) else $error("command while gated");
  actIllegal_a: assert property ( // R02
    (cmdLive && dec.op == CMD_ACTIVE && tState != BANK_IDLE) |-> !okAny ##1 illegalCmd)
    else $error("activate of busy bank taken");
  bstStop_a: assert property ( // R09
    (okBst && burstOn_q) |=> !burstOn_q) else $error("burst stop ignored");
  nopHold_a: assert property ( // R21
    (!isCmd && burstOn_q && beatCnt_q != BlCnt) |=> burstOn_q && $stable(burstBank_q))
    else $error("nop disturbed burst");
endmodule
`default_nettype wire

// ==== sdram_ctrl_model.sv ====
// controller-side model: command records to pin levels
`timescale 1ns/100ps
`default_nettype none
`include "sdram_bank_map.svh"
module sdram_ctrl_model
  import sdram_bank_pkg::*;
(
  input  wire logic  allIdle,
  input  wire logic  lax,
  input  wire cmd_s  req,
  output var  logic  csN,
  output var  logic  rasN,
  output var  logic  casN,
  output var  logic  weN,
  output var  bank_t bankSel,
  output var  logic  apBit
);
  localparam logic [2:0] STROBES [9] = '{`STROBE_NOP, `STROBE_NOP, `STROBE_ACTIVE,
    `STROBE_READ, `STROBE_WRITE, `STROBE_BURST_STOP, `STROBE_PRECHARGE,
    `STROBE_REFRESH, `STROBE_MODE_LOAD};
  wire logic hold;
  // refresh and mode load wait for all banks idle unless told to misbehave
  assign hold = (req.op inside {CMD_REFRESH, CMD_MODE_LOAD}) && !allIdle && !lax;
  assign csN = (req.op == CMD_INHIBIT) || hold;
  assign {rasN, casN, weN} = hold ? `STROBE_NOP : STROBES[req.op];
  assign bankSel = req.bank;
  assign apBit = req.autoPre;
endmodule
`default_nettype wire

// ==== sdram_interbank_interrupt_rules_test.sv ====
// self-checking bench for the inter-bank command tracker
`timescale 1ns/100ps
`default_nettype none
module sdram_interbank_interrupt_rules_test import sdram_bank_pkg::*;;
  logic              clk, rst, cke, dqm, lax;
  cmd_s              req;
  logic              csN, rasN, casN, weN, apBit;
  bank_t             bankSel, readBank, writeBank;
  bank_state_e [3:0] bankState;
  logic [3:0]        prechargeStart;
  logic              readValid, dqDriveEn, writeAccept, allIdle, selfRefresh, illegalCmd;
  int                n_mismatch, n_tests, seed;
  sdram_bank_ctrl dut_u (.clk(clk), .rst(rst), .cke(cke), .csN(csN), .rasN(rasN),
    .casN(casN), .weN(weN), .bankSel(bankSel), .apBit(apBit), .dqm(dqm),
    .bankState(bankState), .prechargeStart(prechargeStart), .readValid(readValid),
    .readBank(readBank), .dqDriveEn(dqDriveEn), .writeAccept(writeAccept),
    .writeBank(writeBank), .allIdle(allIdle), .selfRefresh(selfRefresh),
    .illegalCmd(illegalCmd));
  sdram_ctrl_model partner_u (.allIdle(allIdle), .lax(lax), .req(req), .csN(csN),
    .rasN(rasN), .casN(casN), .weN(weN), .bankSel(bankSel), .apBit(apBit));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic issue(input cmd_e op, input int bank, input logic ap);
    req = '{op, bank_t'(bank), ap};
    @(negedge clk);
    req = '{CMD_NOP, 2'h0, 1'b0};
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic close_out;
    $display("mismatches=%0d tests=%0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #20000;
    n_mismatch++;
    close_out;
  end
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    seed = 32'h3fb4;
    {rst, cke, dqm, lax} = 4'hc;
    req = '{CMD_NOP, 2'h0, 1'b0};
    idle(10);
    rst = 1'b0;
    idle(2);
    check(allIdle, 16'h1);
    check(selfRefresh, 16'h0);
    cke = 1'b0;
    issue(CMD_ACTIVE, 2, 1'b0);
    check(bankState[2], BANK_IDLE);
    cke = 1'b1;
    idle(2);
    issue(CMD_ACTIVE, 0, 1'b0);
    check(bankState[0], BANK_ACTIVATING);
    issue(CMD_ACTIVE, 1, 1'b0);
    idle(2);
    check(bankState[0], BANK_ACTIVE);
    idle(1);
    repeat (8) begin
      req = '{($random(seed) & 1) ? CMD_INHIBIT : CMD_NOP, 2'($random(seed)), 1'($random(seed))};
      @(negedge clk);
      check(bankState[1:0], {BANK_ACTIVE, BANK_ACTIVE});
    end
    req = '{CMD_NOP, 2'h0, 1'b0};
    issue(CMD_ACTIVE, 0, 1'b0);
    check(illegalCmd, 16'h1);
    check(bankState[0], BANK_ACTIVE);
    issue(CMD_READ, 0, 1'b1);
    check(bankState[0], BANK_READ_AP);
    issue(CMD_READ, 1, 1'b0);
    check(prechargeStart, 16'h1);
    check(bankState[1], BANK_READ);
    dqm = 1'b1;
    idle(1);
    check({readValid, readBank}, 16'h4);
    check(dqDriveEn, 16'h1);
    dqm = 1'b0;
    idle(1);
    check({readValid, readBank}, 16'h5);
    check(dqDriveEn, 16'h0);
    idle(1);
    check(bankState[0], BANK_IDLE);
    issue(CMD_WRITE, 1, 1'b1);
    check(bankState[1], BANK_WRITE_AP);
    check({writeAccept, writeBank}, 16'h5);
    lax = 1'b1;
    issue(CMD_REFRESH, 0, 1'b0);
    check(illegalCmd, 16'h1);
    check(writeAccept, 16'h1);
    lax = 1'b0;
    issue(CMD_BURST_STOP, 3, 1'b0);
    check(writeAccept, 16'h0);
    idle(4);
    close_out;
  end
endmodule
`default_nettype wire
